// [rsc_bus_clk.sv]
// Bus clock output divider with a one-cycle pulse on each rising edge.
`timescale 1ns/1ps
module rsc_bus_clk #(
  parameter int HALF_PERIOD = 2
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Divided clock
  output logic bus_clock_output,
  output logic bus_rise
);

  localparam int CW = (HALF_PERIOD > 1) ? $clog2(HALF_PERIOD) : 1;
  localparam logic [CW-1:0] LAST = CW'(HALF_PERIOD - 1);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic clk_r;
  logic clk_nxt;
  logic rise_r;
  logic rise_nxt;

  always_comb begin
    cnt_nxt = cnt_r + CW'(1);
    clk_nxt = clk_r;
    rise_nxt = 1'b0;
    if (cnt_r == LAST) begin
      cnt_nxt = '0;
      clk_nxt = !clk_r;
      rise_nxt = !clk_r;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_r <= '0;
      clk_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      clk_r <= clk_nxt;
      rise_r <= rise_nxt;
    end
  end

  assign bus_clock_output = clk_r;
  assign bus_rise = rise_r;

endmodule : rsc_bus_clk

// [rsc_override_model.sv]
// Behavioural model of the outside override logic that drives the strap pins through reset.
`timescale 1ns/1ps
module rsc_override_model (
  // Clock and device handover signals
  input wire logic clk_sys,
  input wire logic reset_output,
  input wire logic bus_clock_output,
  // Values to present while reset output is high
  input wire logic [31:0] ovr_data,
  input wire logic [7:0] ovr_pa,
  input wire logic [7:0] ovr_pb,
  input wire logic ovr_pll,
  input wire logic ovr_en_n,
  // Pin levels seen by the device
  output logic [31:0] data_in,
  output logic [7:0] port_a_in,
  output logic [7:0] port_b_in,
  output logic pll_enable_strap,
  output logic config_override_enable_n
);
  logic hold_r = 1'b1;
  logic bus_q_r = 1'b0;
  logic [31:0] float_r = 32'h5a5a_a5a5;
  logic drive;

  // An unknown reset output at power-up is treated as asserted, so straps are driven from time zero.
  assign drive = (reset_output !== 1'b0) || hold_r;

  always @(posedge clk_sys) begin
    bus_q_r <= bus_clock_output;
    float_r <= ~float_r;
    if (reset_output !== 1'b0) begin
      hold_r <= 1'b1;
    end else if (bus_clock_output && !bus_q_r) begin
      hold_r <= 1'b0;
    end
  end

  // Released lines toggle every cycle, so the pin synchroniser never accepts them and keeps the last strap level.
  assign data_in = drive ? ovr_data : float_r;
  assign port_a_in = drive ? ovr_pa : float_r[7:0];
  assign port_b_in = drive ? ovr_pb : float_r[15:8];
  assign pll_enable_strap = ovr_pll;
  // The override-enable pin has a weak pull-up once the model lets go of it.
  assign config_override_enable_n = drive ? ovr_en_n : 1'b1;
endmodule : rsc_override_model

// [rsc_pin_sync.sv]
// Three-stage pin synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module rsc_pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Pin side
  input wire logic [WIDTH-1:0] pin_in,
  // Core side
  output logic [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] out_r;
  logic [WIDTH-1:0] out_nxt;

  // The stages keep sampling during reset so straps are settled when reset releases.
  always_ff @(posedge clk_sys) begin
    s1_r <= pin_in;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_agree
      always_comb begin
        out_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : out_r[g];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    out_r <= out_nxt;
  end

  assign pin_sync = out_r;

endmodule : rsc_pin_sync

// [rsc_pkg.sv]
// Package with constants, types and decode functions of the reset strap configuration block.
package rsc_pkg;

  // Read-only default configuration word and its field positions.
  localparam logic [7:0] RSC_DEFAULT_CFG = 8'hc8;
  localparam int RSC_DEF_MODE_BIT = 0;
  localparam int RSC_DEF_BOOT_EXT_BIT = 2;
  localparam int RSC_DEF_BOOT_PS_BIT = 3;
  localparam int RSC_DEF_PAD_BIT = 5;
  localparam int RSC_DEF_PLL_REF_BIT = 6;
  localparam int RSC_DEF_PLL_SEL_BIT = 7;

  // Data pin positions that carry override values.
  localparam int RSC_D_MODE0 = 16;
  localparam int RSC_D_MODE1 = 17;
  localparam int RSC_D_BOOT_EXT = 18;
  localparam int RSC_D_BOOT_PS = 19;
  localparam int RSC_D_PAD = 21;
  localparam int RSC_D_PLL_REF = 22;
  localparam int RSC_D_PLL_SEL = 23;
  localparam int RSC_D_MODE2 = 26;

  // Strap pins that the outside must drive during reset.
  localparam logic [31:0] RSC_DATA_STRAP_MASK = 32'h04ef_0000;
  localparam logic [7:0] RSC_PA_STRAP_MASK = 8'h14;
  localparam logic [7:0] RSC_PB_STRAP_MASK = 8'hef;

  // Bus clock rising edges to wait after reset output negates before driving pins.
  localparam logic [1:0] RSC_BUS_RISE_WAIT = 2'h2;

  typedef enum logic [1:0] {
    RSC_MODE_MASTER = 2'b00,
    RSC_MODE_SINGLE = 2'b01,
    RSC_MODE_FAST = 2'b10,
    RSC_MODE_EMUL = 2'b11
  } rsc_mode_e;

  typedef enum logic [1:0] {
    RSC_CLK_EXT = 2'b00,
    RSC_CLK_PLL_1TO1 = 2'b01,
    RSC_CLK_PLL_EXTREF = 2'b10,
    RSC_CLK_PLL_XTAL = 2'b11
  } rsc_clk_e;

  typedef enum logic [1:0] {
    RSC_ST_RESET = 2'b00,
    RSC_ST_WAIT = 2'b01,
    RSC_ST_RUN = 2'b10
  } rsc_state_e;

  typedef struct packed {
    rsc_mode_e chip_mode;
    logic boot_external;
    logic boot_port_32;
    logic pad_full;
    rsc_clk_e clock_mode;
    logic override_used;
  } rsc_cfg_s;

  typedef struct packed {
    logic [31:0] data;
    logic [7:0] port_a;
    logic [7:0] port_b;
    logic pll_enable_strap;
    logic config_override_enable_n;
  } rsc_strap_s;

  localparam int RSC_STRAP_W = $bits(rsc_strap_s);

  // Chip mode from three pin levels: 111 master, 110 single, 10x fast, 0xx emulation.
  function automatic rsc_mode_e rsc_decode_mode(input logic [2:0] bits);
    if (!bits[2]) begin
      return RSC_MODE_EMUL;
    end else if (!bits[1]) begin
      return RSC_MODE_FAST;
    end else if (bits[0]) begin
      return RSC_MODE_MASTER;
    end
    return RSC_MODE_SINGLE;
  endfunction : rsc_decode_mode

  // Clock mode from enable strap and two selects: 0xx external, 10x 1:1, 110 ext ref, 111 crystal.
  function automatic rsc_clk_e rsc_decode_clk(input logic [2:0] bits);
    if (!bits[2]) begin
      return RSC_CLK_EXT;
    end else if (!bits[1]) begin
      return RSC_CLK_PLL_1TO1;
    end else if (bits[0]) begin
      return RSC_CLK_PLL_XTAL;
    end
    return RSC_CLK_PLL_EXTREF;
  endfunction : rsc_decode_clk

endpackage : rsc_pkg

// [rsc_top.sv]
// Reset-time strap capture and chip configuration with pin handover control.
//
// Overview of operation
// [RULE1] From reset start all override pins and the PLL strap are inputs.
// [RULE2] Outside logic drives data, port A and port B straps throughout reset.
// [RULE3] Override-enable pin is config input in reset, mode-defined function afterwards.
// [RULE4] Without override, configuration comes from defaults and data pins are ignored.
// [RULE5] Without override, configuration outputs equal the default register reset value.
// [RULE6] With override, configuration outputs follow the sampled data pin levels.
// [RULE7] Mode pins 26,17,16: 111 master, 110 single, 10x fast, 0xx emulation.
// [RULE8] Boot pins 19,18: x0 internal 32-bit, 01 external 16-bit, 11 external 32-bit.
// [RULE9] Pad strength from data pin 21; default is default strength.
// [RULE10] PLL strap with pins 23,22: 0xx external, 10x 1:1, 110 ext ref, 111 crystal.
// [RULE11] Default clock mode is normal PLL with crystal reference.
// [RULE12] Data pins outside the strap set never affect configuration.
// [RULE13] Outside logic drives straps while reset output is high, releases within one bus clock.
// [RULE14] Pins become outputs only a full bus clock cycle after reset output negates.
// [RULE15] Chip mode and clock mode are frozen after reset; software cannot change them.
// [RULE16] Pad strength stays writable by software after reset.
// [RULE17] Straps captured at reset release and held until the next reset.
`timescale 1ns/1ps
module rsc_top #(
  parameter int BUS_HALF_PERIOD = 2
) (
  // Clock and internal reset
  input wire logic clk_sys,
  input wire logic rst,
  // Strap pins, input side
  input wire logic [31:0] data_in,
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_b_in,
  input wire logic pll_enable_strap,
  input wire logic config_override_enable_n,
  // Pin drive requests from the core after reset
  input wire logic [31:0] core_data_out,
  input wire logic [31:0] core_data_oe,
  input wire logic [7:0] core_port_a_out,
  input wire logic [7:0] core_port_a_oe,
  input wire logic [7:0] core_port_b_out,
  input wire logic [7:0] core_port_b_oe,
  // Pin drive, output side
  output logic [31:0] data_out,
  output logic [31:0] data_oe,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe,
  // Reset handover
  output logic reset_output,
  output logic bus_clock_output,
  output logic override_pin_is_config,
  // Pad strength software access
  input wire logic pad_load_wr,
  input wire logic pad_load_value,
  // Captured configuration
  output rsc_pkg::rsc_cfg_s chip_cfg,
  output logic [2:0] chip_mode_bits
);
  import rsc_pkg::*;

  rsc_strap_s strap_raw;
  rsc_strap_s strap;
  logic bus_rise;

  assign strap_raw = '{data: data_in, port_a: port_a_in, port_b: port_b_in,
                       pll_enable_strap: pll_enable_strap, config_override_enable_n: config_override_enable_n};

  rsc_pin_sync #(
    .WIDTH(RSC_STRAP_W)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in(strap_raw),
    .pin_sync(strap)
  );

  rsc_bus_clk #(
    .HALF_PERIOD(BUS_HALF_PERIOD)
  ) u_bus_clk (
    .clk_sys(clk_sys),
    .rst(rst),
    .bus_clock_output(bus_clock_output),
    .bus_rise(bus_rise)
  );

  // Configuration words built from defaults and from override pins.
  rsc_cfg_s cfg_default;
  rsc_cfg_s cfg_override;
  logic [2:0] mode_pins;
  logic [31:0] data_straps;

  always_comb begin
    cfg_default.chip_mode = RSC_DEFAULT_CFG[RSC_DEF_MODE_BIT] ? RSC_MODE_MASTER : RSC_MODE_SINGLE; // RULE7
    cfg_default.boot_external = RSC_DEFAULT_CFG[RSC_DEF_BOOT_EXT_BIT]; // RULE8
    cfg_default.boot_port_32 = RSC_DEFAULT_CFG[RSC_DEF_BOOT_PS_BIT];
    cfg_default.pad_full = RSC_DEFAULT_CFG[RSC_DEF_PAD_BIT]; // RULE9
    cfg_default.clock_mode = rsc_decode_clk({1'b1, RSC_DEFAULT_CFG[RSC_DEF_PLL_SEL_BIT],
                                             RSC_DEFAULT_CFG[RSC_DEF_PLL_REF_BIT]}); // RULE11
    cfg_default.override_used = 1'b0; // RULE5
  end

  // Only the strap set passes; every other data pin is masked off.
  assign data_straps = strap.data & RSC_DATA_STRAP_MASK; // RULE12
  assign mode_pins = {data_straps[RSC_D_MODE2], data_straps[RSC_D_MODE1], data_straps[RSC_D_MODE0]};

  always_comb begin
    cfg_override.chip_mode = rsc_decode_mode(mode_pins); // RULE7
    cfg_override.boot_external = data_straps[RSC_D_BOOT_EXT]; // RULE8
    // An internal boot always runs at 32-bit port size.
    cfg_override.boot_port_32 = data_straps[RSC_D_BOOT_EXT] ? data_straps[RSC_D_BOOT_PS] : 1'b1;
    cfg_override.pad_full = data_straps[RSC_D_PAD]; // RULE9
    cfg_override.clock_mode = rsc_decode_clk({strap.pll_enable_strap, data_straps[RSC_D_PLL_SEL],
                                              data_straps[RSC_D_PLL_REF]}); // RULE10
    cfg_override.override_used = 1'b1; // RULE6
  end

  // Handover state, captured configuration and pad strength.
  rsc_state_e st_r;
  rsc_state_e st_nxt;
  rsc_cfg_s cfg_r;
  rsc_cfg_s cfg_nxt;
  logic [2:0] mode_bits_r;
  logic [2:0] mode_bits_nxt;
  logic [1:0] rise_cnt_r;
  logic [1:0] rise_cnt_nxt;
  logic reset_out_r;
  logic reset_out_nxt;
  logic pins_en_r;
  logic pins_en_nxt;
  logic capture;

  assign capture = (st_r == RSC_ST_RESET); // RULE17

  always_comb begin
    st_nxt = st_r;
    cfg_nxt = cfg_r;
    mode_bits_nxt = mode_bits_r;
    rise_cnt_nxt = rise_cnt_r;
    reset_out_nxt = reset_out_r;
    pins_en_nxt = pins_en_r;
    unique case (st_r)
      RSC_ST_RESET: begin
        // First edge after release: sample the settled straps once.
        if (strap.config_override_enable_n) begin
          cfg_nxt = cfg_default; // RULE4
          mode_bits_nxt = {1'b1, 1'b1, RSC_DEFAULT_CFG[RSC_DEF_MODE_BIT]};
        end else begin
          cfg_nxt = cfg_override; // RULE6
          mode_bits_nxt = mode_pins;
        end
        reset_out_nxt = 1'b0;
        rise_cnt_nxt = '0;
        st_nxt = RSC_ST_WAIT;
      end
      RSC_ST_WAIT: begin
        // Two rising edges after negation span at least one full bus clock cycle.
        if (bus_rise) begin
          rise_cnt_nxt = rise_cnt_r + 2'h1;
          if (rise_cnt_r + 2'h1 == RSC_BUS_RISE_WAIT) begin
            pins_en_nxt = 1'b1; // RULE14
            st_nxt = RSC_ST_RUN;
          end
        end
      end
      RSC_ST_RUN: begin
        // Mode and clock fields have no write path after capture.
        if (pad_load_wr) begin
          cfg_nxt.pad_full = pad_load_value; // RULE16
        end
      end
      default: begin
        st_nxt = RSC_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= RSC_ST_RESET;
      cfg_r <= '0;
      mode_bits_r <= '0;
      rise_cnt_r <= '0;
      reset_out_r <= 1'b1;
      pins_en_r <= 1'b0; // RULE1
    end else begin
      st_r <= st_nxt;
      cfg_r <= cfg_nxt; // RULE15
      mode_bits_r <= mode_bits_nxt;
      rise_cnt_r <= rise_cnt_nxt;
      reset_out_r <= reset_out_nxt;
      pins_en_r <= pins_en_nxt;
    end
  end

  // Pin drive is gated until handover completes, so straps are never contended.
  assign data_oe = pins_en_r ? core_data_oe : '0; // RULE14
  assign port_a_oe = pins_en_r ? core_port_a_oe : '0;
  assign port_b_oe = pins_en_r ? core_port_b_oe : '0;
  assign data_out = core_data_out;
  assign port_a_out = core_port_a_out;
  assign port_b_out = core_port_b_out;
  // Strap drivers outside release on this signal.
  assign reset_output = reset_out_r; // RULE13
  assign override_pin_is_config = (st_r == RSC_ST_RESET); // RULE3
  assign chip_cfg = cfg_r;
  assign chip_mode_bits = mode_bits_r;

  // Checks on handover and capture.
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_release;
    $fell(reset_output);
  endsequence

  sequence s_no_drive2;
    (data_oe == '0 && port_a_oe == '0 && port_b_oe == '0) [*2];
  endsequence

  a_pins_input_rst: assert property (disable iff (1'b0) rst |=> // RULE1
      data_oe == '0 && port_a_oe == '0 && port_b_oe == '0)
    else $error("strap pins driven during reset");

  a_handover_gap: assert property (s_release |-> s_no_drive2) // RULE14
    else $error("pins driven too soon after reset output negated");

  // Cycles since reset output negated; it saturates once a full bus clock cycle has passed.
  localparam int GAP_MIN = 2 * BUS_HALF_PERIOD;
  localparam int GAP_W = $clog2(GAP_MIN + 1);
  localparam int HANDOVER_CYC = 3 * BUS_HALF_PERIOD;
  logic [GAP_W-1:0] gap_cnt_r;
  logic [GAP_W-1:0] gap_cnt_nxt;

  always_comb begin
    gap_cnt_nxt = gap_cnt_r;
    if (!reset_output && gap_cnt_r != GAP_W'(GAP_MIN)) begin
      gap_cnt_nxt = gap_cnt_r + GAP_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      gap_cnt_r <= '0;
    end else begin
      gap_cnt_r <= gap_cnt_nxt;
    end
  end

  a_handover_min: assert property (gap_cnt_r != GAP_W'(GAP_MIN) |-> // RULE14
      data_oe == '0 && port_a_oe == '0 && port_b_oe == '0)
    else $error("pins driven within one bus clock cycle of reset output negating");

  a_handover_done: assert property (s_release |-> ##[1:HANDOVER_CYC] // RULE14
      data_oe == core_data_oe && port_a_oe == core_port_a_oe && port_b_oe == core_port_b_oe)
    else $error("pins not handed to the core after the handover wait");

  a_reset_out_high: assert property (disable iff (1'b0) rst |=> reset_output) // RULE13
    else $error("reset output low during reset");

  a_capture_release: assert property (capture |=> !reset_output && !override_pin_is_config) // RULE17
    else $error("reset output or pin role not released after capture");

  a_cfg_held_wait: assert property (st_r == RSC_ST_WAIT |=> $stable(chip_cfg) && $stable(chip_mode_bits)) // RULE17
    else $error("configuration changed during handover wait");

  a_default_bits: assert property (capture && strap.config_override_enable_n |=> // RULE4
      chip_mode_bits == 3'b110 && !chip_cfg.override_used)
    else $error("default mode bits wrong");

  a_cfg_pin_role: assert property (disable iff (1'b0) rst |=> override_pin_is_config ##1 !rst [*2] |-> !override_pin_is_config) // RULE3
    else $error("override pin role wrong around reset");

  a_default_cfg: assert property (capture && strap.config_override_enable_n |=>
      chip_cfg.chip_mode == RSC_MODE_SINGLE && !chip_cfg.boot_external && chip_cfg.boot_port_32 && !chip_cfg.pad_full) // RULE5
    else $error("default configuration not applied");

  a_default_clk: assert property (capture && strap.config_override_enable_n |=> chip_cfg.clock_mode == RSC_CLK_PLL_XTAL) // RULE11
    else $error("default clock mode wrong");

  a_override_mode: assert property (capture && !strap.config_override_enable_n && mode_pins == 3'b110 |=>
      chip_cfg.chip_mode == RSC_MODE_SINGLE && chip_cfg.override_used) // RULE7
    else $error("override chip mode wrong");

  a_override_boot: assert property (capture && !strap.config_override_enable_n |=>
      chip_cfg.boot_external == $past(strap.data[RSC_D_BOOT_EXT])) // RULE8
    else $error("override boot select wrong");

  a_override_pad: assert property (capture && !strap.config_override_enable_n |=> chip_cfg.pad_full == $past(strap.data[RSC_D_PAD])) // RULE9
    else $error("override pad strength wrong");

  a_override_clk: assert property (capture && !strap.config_override_enable_n && !strap.pll_enable_strap |=>
      chip_cfg.clock_mode == RSC_CLK_EXT) // RULE10
    else $error("override clock mode wrong");

  a_override_1to1: assert property (capture && !strap.config_override_enable_n && // RULE10
      strap.pll_enable_strap && !strap.data[RSC_D_PLL_SEL] |=> chip_cfg.clock_mode == RSC_CLK_PLL_1TO1)
    else $error("override one to one clock mode wrong");

  a_override_xtal: assert property (capture && !strap.config_override_enable_n && // RULE10
      strap.pll_enable_strap && strap.data[RSC_D_PLL_SEL] && strap.data[RSC_D_PLL_REF] |=>
      chip_cfg.clock_mode == RSC_CLK_PLL_XTAL)
    else $error("override crystal clock mode wrong");

  a_override_ps: assert property (capture && !strap.config_override_enable_n |=> // RULE8
      chip_cfg.boot_port_32 == ($past(strap.data[RSC_D_BOOT_EXT]) ? $past(strap.data[RSC_D_BOOT_PS]) : 1'b1))
    else $error("override boot port size wrong");

  a_override_emul: assert property (capture && !strap.config_override_enable_n && // RULE7
      !mode_pins[2] |=> chip_cfg.chip_mode == RSC_MODE_EMUL && chip_mode_bits == $past(mode_pins))
    else $error("override emulation mode wrong");

  a_override_fast: assert property (capture && !strap.config_override_enable_n && // RULE7
      mode_pins[2:1] == 2'b10 |=> chip_cfg.chip_mode == RSC_MODE_FAST)
    else $error("override fast mode wrong");

  a_override_master: assert property (capture && !strap.config_override_enable_n && // RULE7
      mode_pins == 3'b111 |=> chip_cfg.chip_mode == RSC_MODE_MASTER)
    else $error("override master mode wrong");

  a_mode_frozen: assert property (st_r != RSC_ST_RESET |=> $stable(chip_cfg.chip_mode) && $stable(chip_cfg.clock_mode)) // RULE15
    else $error("mode changed after reset");

  a_pad_write: assert property (st_r == RSC_ST_RUN && pad_load_wr |=> chip_cfg.pad_full == $past(pad_load_value)) // RULE16
    else $error("pad strength write lost");

endmodule : rsc_top

// [rsc_top_tb.sv]
// Self-checking testbench of the reset strap configuration block.
`timescale 1ns/1ps
module rsc_top_tb;
  import rsc_pkg::*;
  localparam int HALF = 2;
  // Strap sets {d26,d17,d16,d19,d18,d21,pll,d23,d22}; together they cover every decode code.
  localparam logic [8:0] CASES [6] = '{9'b111_101_111, 9'b110_010_110, 9'b100_111_100,
                                       9'b101_000_011, 9'b011_110_101, 9'b000_011_000};
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [31:0] data_in, data_out, data_oe, ovr_data = 32'h0;
  logic [7:0] port_a_in, port_b_in, port_a_out, port_a_oe, port_b_out, port_b_oe;
  logic [7:0] ovr_pa = 8'h0, ovr_pb = 8'h0;
  logic [31:0] core_data_out = 32'h1234_abcd, core_data_oe = 32'hffff_ffff;
  logic [7:0] core_port_a_out = 8'h3c, core_port_a_oe = 8'hff, core_port_b_out = 8'hc3, core_port_b_oe = 8'h7e;
  logic pll_enable_strap, config_override_enable_n, ovr_pll = 1'b1, ovr_en_n = 1'b1;
  logic reset_output, bus_clock_output, override_pin_is_config;
  logic pad_load_wr = 1'b0, pad_load_value = 1'b0;
  rsc_cfg_s chip_cfg, exp;
  logic [2:0] chip_mode_bits;
  int err_total = 0;
  int comparisons = 0;

  always #25 clk_sys = ~clk_sys;

  rsc_override_model partner (.clk_sys(clk_sys), .reset_output(reset_output), .bus_clock_output(bus_clock_output),
    .ovr_data(ovr_data), .ovr_pa(ovr_pa), .ovr_pb(ovr_pb), .ovr_pll(ovr_pll), .ovr_en_n(ovr_en_n),
    .data_in(data_in), .port_a_in(port_a_in), .port_b_in(port_b_in), .pll_enable_strap(pll_enable_strap),
    .config_override_enable_n(config_override_enable_n));

  rsc_top #(.BUS_HALF_PERIOD(HALF)) dut (.clk_sys(clk_sys), .rst(rst), .data_in(data_in), .port_a_in(port_a_in),
    .port_b_in(port_b_in), .pll_enable_strap(pll_enable_strap), .config_override_enable_n(config_override_enable_n),
    .core_data_out(core_data_out), .core_data_oe(core_data_oe), .core_port_a_out(core_port_a_out),
    .core_port_a_oe(core_port_a_oe), .core_port_b_out(core_port_b_out), .core_port_b_oe(core_port_b_oe),
    .data_out(data_out), .data_oe(data_oe), .port_a_out(port_a_out), .port_a_oe(port_a_oe),
    .port_b_out(port_b_out), .port_b_oe(port_b_oe), .reset_output(reset_output),
    .bus_clock_output(bus_clock_output), .override_pin_is_config(override_pin_is_config),
    .pad_load_wr(pad_load_wr), .pad_load_value(pad_load_value), .chip_cfg(chip_cfg),
    .chip_mode_bits(chip_mode_bits));

  task check(input string what, input logic [31:0] want, input logic [31:0] got);
    comparisons++;
    if (got !== want) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, want, got);
    end
  endtask : check

  task conclude;
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  function automatic rsc_cfg_s exp_cfg(input logic en_n, input logic [8:0] s);
    rsc_cfg_s c;
    if (en_n) begin
      c = '{RSC_MODE_SINGLE, 1'b0, 1'b1, 1'b0, RSC_CLK_PLL_XTAL, 1'b0};
      return c;
    end
    c.chip_mode = !s[8] ? RSC_MODE_EMUL : !s[7] ? RSC_MODE_FAST : s[6] ? RSC_MODE_MASTER : RSC_MODE_SINGLE;
    c.boot_external = s[4];
    c.boot_port_32 = s[4] ? s[5] : 1'b1;
    c.pad_full = s[3];
    c.clock_mode = !s[2] ? RSC_CLK_EXT : !s[1] ? RSC_CLK_PLL_1TO1 : s[0] ? RSC_CLK_PLL_XTAL : RSC_CLK_PLL_EXTREF;
    c.override_used = 1'b1;
    return c;
  endfunction : exp_cfg

  // One full reset: present straps, hold reset six cycles, capture, then watch the pin handover.
  task run_reset(input logic en_n, input logic [8:0] s, input logic [31:0] noise);
    int n;
    @(posedge clk_sys);
    ovr_en_n <= en_n;
    ovr_pll <= s[2];
    ovr_data <= (noise & ~RSC_DATA_STRAP_MASK) | {5'h0, s[8], 2'h0, s[1], s[0], s[3], 1'b0, s[5], s[4], s[7], s[6], 16'h0};
    ovr_pa <= noise[7:0];
    ovr_pb <= noise[15:8];
    rst <= 1'b1;
    exp = exp_cfg(en_n, s);
    repeat (5) @(posedge clk_sys);
    pad_load_wr <= 1'b1;
    pad_load_value <= ~exp.pad_full;
    @(negedge clk_sys);
    check("oe in reset", 32'h0, data_oe | {16'h0, port_a_oe, port_b_oe});
    check("override pin role", 32'h1, {31'h0, override_pin_is_config});
    check("reset output", 32'h1, {31'h0, reset_output});
    check("bus clock in reset", 32'h0, {31'h0, bus_clock_output});
    @(posedge clk_sys);
    rst <= 1'b0;
    // The design sees reset low only at the next edge, which is the capture edge.
    @(posedge clk_sys);
    @(negedge clk_sys);
    check("cfg captured", {24'h0, exp}, {24'h0, chip_cfg});
    check("mode bits", {29'h0, en_n ? 3'b110 : s[8:6]}, {29'h0, chip_mode_bits});
    check("override pin after", 32'h0, {31'h0, override_pin_is_config});
    check("reset output low", 32'h0, {31'h0, reset_output});
    for (int i = 0; i < 2 * HALF; i++) begin
      @(posedge clk_sys);
      pad_load_wr <= 1'b0;
      @(negedge clk_sys);
      check("oe held off", 32'h0, data_oe | {16'h0, port_a_oe, port_b_oe});
    end
    n = 0;
    while (data_oe !== core_data_oe && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    check("data oe", core_data_oe, data_oe);
    check("port oe", {16'h0, core_port_a_oe, core_port_b_oe}, {16'h0, port_a_oe, port_b_oe});
    check("data out", core_data_out, data_out);
    check("port out", {16'h0, core_port_a_out, core_port_b_out}, {16'h0, port_a_out, port_b_out});
    check("cfg after refused write", {24'h0, exp}, {24'h0, chip_cfg});
  endtask : run_reset

  // Back-to-back pad writes in run, then a long hold with the pins toggling.
  task run_writes;
    logic [2:0] v;
    logic bq;
    int rises;
    v = {~exp.pad_full, exp.pad_full, ~exp.pad_full};
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys);
      pad_load_wr <= 1'b1;
      pad_load_value <= v[k];
      if (k > 0) begin
        @(negedge clk_sys);
        check("pad write", {31'h0, v[k-1]}, {31'h0, chip_cfg.pad_full});
      end
    end
    @(posedge clk_sys);
    pad_load_wr <= 1'b0;
    @(negedge clk_sys);
    bq = bus_clock_output;
    rises = 0;
    repeat (16) begin
      @(negedge clk_sys);
      if (bus_clock_output && !bq) begin
        rises++;
      end
      bq = bus_clock_output;
    end
    exp.pad_full = v[2];
    check("cfg frozen", {24'h0, exp}, {24'h0, chip_cfg});
    check("bus clock rises", 16 / (2 * HALF), rises);
  endtask : run_writes

  initial begin
    run_reset(1'b1, 9'b011_011_010, 32'hffff_ffff);
    run_writes();
    $display("test default done");
    for (int i = 0; i < 6; i++) begin
      run_reset(1'b0, CASES[i], i[0] ? 32'hffff_ffff : 32'h0);
      if (i == 0) begin
        run_writes();
      end
      $display("test override %0d done", i);
    end
    conclude();
  end

  // About 140 cycles are expected; the limit leaves a wide margin.
  initial begin
    #(50 * 4000);
    err_total++;
    $display("[ERR] watchdog expected finish seen timeout");
    conclude();
  end
endmodule : rsc_top_tb
